// ---- core/sfpe_top.sv ----
// SPI flash program and erase sequencer with link-side frame capture
`timescale 1ns/1ps
module sfpe_top #(
    parameter int unsigned PROG_CYC = sfpe_pkg::PROG_CYC,
    parameter int unsigned SECT_ERASE_CYC = sfpe_pkg::SECT_ERASE_CYC,
    parameter int unsigned BLK_ERASE_CYC = sfpe_pkg::BLK_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYC =
        32'(sfpe_pkg::CHIP_ERASE_CYC)
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic soOe,
    input wire logic wp_n,
    input wire logic blockProtectBitA,
    input wire logic blockProtectBitB,
    input wire logic blockProtectBitC,
    input wire logic blockProtectBitD,
    input wire logic hwProtectEnableBit,
    output logic hwProtectActive,
    output logic writeEnableLatch,
    output logic busy,
    output logic [16:0] arrAddr,
    output logic [7:0] arrWrData,
    output logic arrWe,
    input wire logic [7:0] arrRdData
);
    // Link-side state, clocked by sck (SPI mode 0, sampled on rise)
    typedef struct packed
    {
        logic frameTgl;
        logic [2:0] bitIdx;
        logic [2:0] byteCnt;
        logic [7:0] shIn;
        logic [7:0] opc;
        logic [23:0] addr;
        logic [7:0] off;
        logic [255:0] mask;
        logic [255:0][7:0] pageBuf;
        logic rdStat;
        logic keep;
        logic [7:0] statSh;
    } sfpe_lnk_t;

    // Sequencer state, clocked by clk
    typedef struct packed
    {
        sfpe_pkg::sfpe_state_t state;
        sfpe_pkg::sfpe_opkind_t kind;
        logic csPrev;
        logic seenTgl;
        logic wel;
        logic busy;
        logic hwProt;
        logic [16:0] cur;
        logic [16:0] last;
        logic [31:0] timer;
        logic [16:0] arrAddr;
        logic [7:0] arrWrData;
        logic arrWe;
        logic [7:0] status;
    } sfpe_seq_t;

    sfpe_lnk_t lnk_q;
    sfpe_lnk_t lnk_d;
    sfpe_seq_t seq_q;
    sfpe_seq_t seq_d;
    logic frameAct_q;
    logic soBit_q;
    logic lnkRst_n;
    logic [7:0] statSync;
    logic [1:0] pinSync;
    logic csSync;
    logic wpSync;
    logic newFrame;
    logic [7:0] newByte;

    // Protected area is always a top-of-array suffix, so a range is
    // locked exactly when its highest byte is locked.
    function automatic logic isLocked(
        input logic [16:0] a,
        input logic bpa,
        input logic bpb,
        input logic bpc,
        input logic bpd
    );
        logic [16:0] bound;
        logic none;
        bound = sfpe_pkg::PROT_ALL;
        none = 1'b0;
        unique case ({bpb, bpa})
            2'h3: bound = sfpe_pkg::PROT_ALL;
            2'h2: bound = sfpe_pkg::PROT_HALF;
            2'h1: bound = sfpe_pkg::PROT_QUARTER;
            2'h0:
            begin
                unique case ({bpd, bpc})
                    2'h0: none = 1'b1;
                    2'h1: bound = sfpe_pkg::PROT_THIRTYSECOND;
                    2'h2: bound = sfpe_pkg::PROT_SIXTEENTH;
                    2'h3: bound = sfpe_pkg::PROT_EIGHTH;
                endcase
            end
        endcase
        return !none && (a >= bound);
    endfunction

    function automatic logic frameLen(
        input sfpe_lnk_t l,
        input logic [2:0] nBytes
    );
        return (l.bitIdx == 3'h0) && (l.byteCnt == nBytes);
    endfunction

    // ---------------- Link domain ----------------
    // Frame flag is cleared by CS high so each falling edge restarts
    assign lnkRst_n = arst_n & ~cs_n;

    always_ff @(posedge sck or negedge lnkRst_n)
    begin
        if (!lnkRst_n)
            frameAct_q <= 1'b0;
        else
            frameAct_q <= 1'b1;
    end

    sfpe_sync #(
        .WIDTH(8),
        .RST_VAL(8'h00)
    ) u_statSync (
        .clk(sck),
        .arst_n(arst_n),
        .d(seq_q.status),
        .q(statSync)
    );

    always_comb
    begin
        lnk_d = lnk_q;
        if (!frameAct_q)
        begin
            lnk_d.frameTgl = ~lnk_q.frameTgl;
            lnk_d.bitIdx = 3'h0;
            lnk_d.byteCnt = 3'h0;
            lnk_d.rdStat = 1'b0;
        end
        newByte = {lnk_d.shIn[6:0], si};
        lnk_d.shIn = newByte;
        if (lnk_d.bitIdx == sfpe_pkg::BIT_LAST)
        begin
            if (lnk_d.byteCnt == 3'h0)
            begin
                lnk_d.opc = newByte;
                lnk_d.rdStat = (newByte == sfpe_pkg::OP_STATUS_READ);
                // A walk in progress still reads the page buffer, so
                // frames during busy must not disturb it.
                lnk_d.keep = statSync[sfpe_pkg::SB_BUSY]
                    || (newByte != sfpe_pkg::OP_PAGE_PROGRAM);
                if (!lnk_d.keep)
                    lnk_d.mask = '0;
            end
            else if (lnk_d.byteCnt < sfpe_pkg::BYTES_ADDR_END)
            begin
                lnk_d.addr = {lnk_d.addr[15:0], newByte};
                lnk_d.off = newByte;
            end
            else if (!lnk_d.keep)
            begin
                // 8-bit offset wraps inside the page; repeats overwrite
                lnk_d.pageBuf[lnk_d.off] = newByte;
                lnk_d.mask[lnk_d.off] = 1'b1;
                lnk_d.off = lnk_d.off + 8'h01;
            end
            if (lnk_d.byteCnt != sfpe_pkg::BYTES_PROGRAM)
                lnk_d.byteCnt = lnk_d.byteCnt + 3'h1;
        end
        // Status byte repeats while clocks continue
        if (lnk_d.bitIdx == sfpe_pkg::BIT_LAST && lnk_d.rdStat)
            lnk_d.statSh = statSync;
        else
            lnk_d.statSh = {lnk_q.statSh[6:0], 1'b0};
        lnk_d.bitIdx = lnk_d.bitIdx + 3'h1;
    end

    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
            lnk_q <= '0;
        else
            lnk_q <= lnk_d;
    end

    // Mode 0 output changes on the falling edge
    always_ff @(negedge sck or negedge arst_n)
    begin
        if (!arst_n)
            soBit_q <= 1'b0;
        else
            soBit_q <= lnk_q.statSh[7];
    end

    assign so = soBit_q;
    assign soOe = frameAct_q & lnk_q.rdStat & ~cs_n;

    // ---------------- Sequencer domain ----------------
    sfpe_sync #(
        .WIDTH(2),
        .RST_VAL(2'h3)
    ) u_pinSync (
        .clk(clk),
        .arst_n(arst_n),
        .d({wp_n, cs_n}),
        .q(pinSync)
    );

    assign csSync = pinSync[0];
    assign wpSync = pinSync[1];

    // Link registers are static once CS is high and sck parked low,
    // so they are read here only after the synchronised CS rise.
    assign newFrame = csSync & ~seq_q.csPrev
        & (lnk_q.frameTgl != seq_q.seenTgl);

    always_comb
    begin
        seq_d = seq_q;
        seq_d.csPrev = csSync;
        seq_d.arrWe = 1'b0;
        seq_d.hwProt = ~wpSync & hwProtectEnableBit;
        if (seq_q.timer != 32'h0)
            seq_d.timer = seq_q.timer - 32'h1;
        if (newFrame)
            seq_d.seenTgl = lnk_q.frameTgl;
        unique case (seq_q.state)
            sfpe_pkg::ST_IDLE:
            begin
                // Busy periods drop every frame; status reads are link-only
                if (newFrame)
                begin
                    unique case (lnk_q.opc)
                        sfpe_pkg::OP_WRITE_ENABLE:
                            if (frameLen(lnk_q, sfpe_pkg::BYTES_CMD_ONLY))
                                seq_d.wel = 1'b1;
                        sfpe_pkg::OP_PAGE_PROGRAM:
                        begin
                            seq_d.kind = sfpe_pkg::OPK_PROG;
                            seq_d.cur = {lnk_q.addr[16:8], 8'h00};
                            seq_d.last = {lnk_q.addr[16:8], 8'hFF};
                            seq_d.timer = 32'(PROG_CYC);
                        end
                        sfpe_pkg::OP_SECTOR_ERASE:
                        begin
                            seq_d.kind = sfpe_pkg::OPK_SECT;
                            seq_d.cur = {lnk_q.addr[16:12], 12'h000};
                            seq_d.last = {lnk_q.addr[16:12], 12'hFFF};
                            seq_d.timer = 32'(SECT_ERASE_CYC);
                        end
                        sfpe_pkg::OP_BLOCK_ERASE:
                        begin
                            seq_d.kind = sfpe_pkg::OPK_BLK;
                            seq_d.cur = {lnk_q.addr[16:15], 15'h0000};
                            seq_d.last = {lnk_q.addr[16:15], 15'h7FFF};
                            seq_d.timer = 32'(BLK_ERASE_CYC);
                        end
                        sfpe_pkg::OP_CHIP_ERASE:
                        begin
                            seq_d.kind = sfpe_pkg::OPK_CHIP;
                            seq_d.cur = sfpe_pkg::ARRAY_FIRST;
                            seq_d.last = sfpe_pkg::ARRAY_LAST;
                            seq_d.timer = 32'(CHIP_ERASE_CYC);
                        end
                        default:
                            seq_d.kind = seq_q.kind;
                    endcase
                    // Start needs the enable latch, a whole-byte frame ending right after
                    // the address for erases or after one or more data bytes for program, and an unlocked target.
                    if (seq_q.wel && (
                        (lnk_q.opc == sfpe_pkg::OP_PAGE_PROGRAM
                            && frameLen(lnk_q, sfpe_pkg::BYTES_PROGRAM)) ||
                        ((lnk_q.opc == sfpe_pkg::OP_SECTOR_ERASE
                            || lnk_q.opc == sfpe_pkg::OP_BLOCK_ERASE
                            || lnk_q.opc == sfpe_pkg::OP_CHIP_ERASE)
                            && frameLen(lnk_q, sfpe_pkg::BYTES_ADDR_END))))
                    begin
                        // Whole array is locked exactly when byte 0 is
                        if (!isLocked((lnk_q.opc == sfpe_pkg::OP_CHIP_ERASE)
                            ? seq_d.cur : seq_d.last, blockProtectBitA,
                                blockProtectBitB, blockProtectBitC,
                                blockProtectBitD))
                        begin
                            seq_d.state = sfpe_pkg::ST_READ;
                            seq_d.busy = 1'b1;
                        end
                        else
                            seq_d.timer = 32'h0;
                    end
                    else
                        seq_d.timer = 32'h0;
                end
            end
            sfpe_pkg::ST_READ:
            begin
                if (seq_q.kind == sfpe_pkg::OPK_PROG)
                begin
                    if (lnk_q.mask[seq_q.cur[7:0]])
                    begin
                        seq_d.arrAddr = seq_q.cur;
                        seq_d.state = sfpe_pkg::ST_WRITE;
                    end
                end
                else if (!isLocked(seq_q.cur, blockProtectBitA,
                    blockProtectBitB, blockProtectBitC,
                    blockProtectBitD))
                begin
                    seq_d.arrAddr = seq_q.cur;
                    seq_d.arrWrData = sfpe_pkg::ERASED_BYTE;
                    seq_d.arrWe = 1'b1;
                end
                if (seq_d.state == sfpe_pkg::ST_READ)
                begin
                    if (seq_q.cur == seq_q.last)
                        seq_d.state = sfpe_pkg::ST_WAIT;
                    else
                        seq_d.cur = seq_q.cur + 17'h1;
                end
            end
            sfpe_pkg::ST_WRITE:
            begin
                // Old AND new: bits can only fall from one to zero
                seq_d.arrWrData =
                    arrRdData & lnk_q.pageBuf[seq_q.cur[7:0]];
                seq_d.arrWe = 1'b1;
                if (seq_q.cur == seq_q.last)
                    seq_d.state = sfpe_pkg::ST_WAIT;
                else
                begin
                    seq_d.cur = seq_q.cur + 17'h1;
                    seq_d.state = sfpe_pkg::ST_READ;
                end
            end
            sfpe_pkg::ST_WAIT:
            begin
                if (seq_q.timer == 32'h0)
                begin
                    seq_d.state = sfpe_pkg::ST_IDLE;
                    seq_d.busy = 1'b0;
                    seq_d.wel = 1'b0;
                end
            end
        endcase
        seq_d.status = 8'h00;
        seq_d.status[sfpe_pkg::SB_BUSY] = seq_d.busy;
        seq_d.status[sfpe_pkg::SB_WEL] = seq_d.wel;
        seq_d.status[sfpe_pkg::SB_BPA] = blockProtectBitA;
        seq_d.status[sfpe_pkg::SB_BPB] = blockProtectBitB;
        seq_d.status[sfpe_pkg::SB_BPC] = blockProtectBitC;
        seq_d.status[sfpe_pkg::SB_BPD] = blockProtectBitD;
        seq_d.status[sfpe_pkg::SB_HWPE] = hwProtectEnableBit;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_q <= '0;
            seq_q.csPrev <= 1'b1;
        end
        else
            seq_q <= seq_d;
    end

    assign hwProtectActive = seq_q.hwProt;
    assign writeEnableLatch = seq_q.wel;
    assign busy = seq_q.busy;
    assign arrAddr = seq_q.arrAddr;
    assign arrWrData = seq_q.arrWrData;
    assign arrWe = seq_q.arrWe;
endmodule

// ---- core/sfpe_pkg.sv ----
// Constants and types for the serial flash program/erase sequencer
package sfpe_pkg;
    localparam int ADDR_W = 17;
    localparam int PAGE_AW = 8;
    localparam int SECTOR_AW = 12;
    localparam int BLOCK_AW = 15;
    localparam int PAGE_BYTES = 256;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
    localparam logic [2:0] BYTES_ADDR_END = 3'h4;
    localparam logic [2:0] BYTES_PROGRAM = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [16:0] ARRAY_FIRST = 17'h00000;
    localparam logic [16:0] ARRAY_LAST = 17'h1FFFF;
    localparam logic [16:0] PROT_ALL = 17'h00000;
    localparam logic [16:0] PROT_HALF = 17'h10000;
    localparam logic [16:0] PROT_QUARTER = 17'h18000;
    localparam logic [16:0] PROT_EIGHTH = 17'h1C000;
    localparam logic [16:0] PROT_SIXTEENTH = 17'h1E000;
    localparam logic [16:0] PROT_THIRTYSECOND = 17'h1F000;
    localparam int SB_BUSY = 0;
    localparam int SB_WEL = 1;
    localparam int SB_BPA = 2;
    localparam int SB_BPB = 3;
    localparam int SB_BPC = 5;
    localparam int SB_BPD = 6;
    localparam int SB_HWPE = 7;
    localparam longint CLK_HZ = 50000000;
    localparam longint CHIP_ERASE_S = 8;
    localparam longint CHIP_ERASE_CYC = CLK_HZ * CHIP_ERASE_S;
    localparam int PROG_CYC = 64;
    localparam int SECT_ERASE_CYC = 256;
    localparam int BLK_ERASE_CYC = 1024;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h3,
        ST_WAIT = 2'h2
    } sfpe_state_t;

    typedef enum logic [1:0]
    {
        OPK_PROG = 2'h0,
        OPK_SECT = 2'h1,
        OPK_BLK = 2'h2,
        OPK_CHIP = 2'h3
    } sfpe_opkind_t;
endpackage

// ---- core/sfpe_sync.sv ----
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module sfpe_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sfpe_sync_st_t;

    sfpe_sync_st_t r_q;
    sfpe_sync_st_t r_d;

    always_comb
    begin
        r_d.meta = d;
        r_d.held = r_q.meta;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r_q <= {RST_VAL, RST_VAL};
        else
            r_q <= r_d;
    end

    assign q = r_q.held;
endmodule

// ---- dv/sfpe_props.sv ----
// Port-level checker for the program/erase sequencer
`timescale 1ns/1ps
module sfpe_props #(
    parameter int unsigned PROG_CYC = 64
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wp_n,
    input wire logic blockProtectBitA,
    input wire logic blockProtectBitB,
    input wire logic blockProtectBitC,
    input wire logic blockProtectBitD,
    input wire logic hwProtectEnableBit,
    input wire logic hwProtectActive,
    input wire logic writeEnableLatch,
    input wire logic busy,
    input wire logic [16:0] arrAddr,
    input wire logic [7:0] arrWrData,
    input wire logic arrWe,
    input wire logic [7:0] arrRdData
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [16:0] lockFrom;
    logic lockOn;
    logic [31:0] busyCnt_q;
    always_comb
    begin
        lockOn = 1'b1;
        lockFrom = sfpe_pkg::PROT_ALL;
        casez ({blockProtectBitD, blockProtectBitC,
                blockProtectBitB, blockProtectBitA})
            4'b??11: lockFrom = sfpe_pkg::PROT_ALL;
            4'b??10: lockFrom = sfpe_pkg::PROT_HALF;
            4'b??01: lockFrom = sfpe_pkg::PROT_QUARTER;
            4'b0100: lockFrom = sfpe_pkg::PROT_THIRTYSECOND;
            4'b1000: lockFrom = sfpe_pkg::PROT_SIXTEENTH;
            4'b1100: lockFrom = sfpe_pkg::PROT_EIGHTH;
            default: lockOn = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            busyCnt_q <= '0;
        else
            busyCnt_q <= busy ? busyCnt_q + 32'h1 : '0;
    end
    we_in_cycle_a: assert property (arrWe |-> busy)
        else $error("array written outside a cycle");
    wel_held_a: assert property (busy |-> writeEnableLatch)
        else $error("latch dropped during a cycle");
    wel_clear_a: assert property ($fell(busy) |-> !writeEnableLatch)
        else $error("latch kept after cycle end");
    busy_needs_wel_a: assert property ($rose(busy) |-> $past(writeEnableLatch))
        else $error("cycle started without latch");
    wel_ignored_a: assert property ($rose(writeEnableLatch) |-> !$past(busy))
        else $error("write enable taken while busy");
    one_to_zero_a: assert property (arrWe && arrWrData != 8'hFF
        |-> (arrWrData & ~arrRdData) == 8'h00)
        else $error("program raised a bit");
    locked_safe_a: assert property (arrWe |-> !(lockOn && arrAddr >= lockFrom))
        else $error("locked byte written");
    hw_prot_on_a: assert property ((!wp_n && hwProtectEnableBit)[*4]
        |-> hwProtectActive)
        else $error("hardware protect not reported");
    hw_prot_off_a: assert property ((wp_n || !hwProtectEnableBit)[*4]
        |-> !hwProtectActive)
        else $error("hardware protect reported wrongly");
    busy_span_a: assert property ($fell(busy) |-> $past(busyCnt_q) + 2 >= PROG_CYC)
        else $error("busy period too short");
endmodule

bind sfpe_top sfpe_props #(.PROG_CYC(PROG_CYC)) i_sfpe_props (
    .clk(clk), .arst_n(arst_n), .wp_n(wp_n),
    .blockProtectBitA(blockProtectBitA), .blockProtectBitB(blockProtectBitB),
    .blockProtectBitC(blockProtectBitC), .blockProtectBitD(blockProtectBitD),
    .hwProtectEnableBit(hwProtectEnableBit),
    .hwProtectActive(hwProtectActive), .writeEnableLatch(writeEnableLatch),
    .busy(busy), .arrAddr(arrAddr), .arrWrData(arrWrData), .arrWe(arrWe),
    .arrRdData(arrRdData));

// ---- dv/sfpe_host.sv ----
// SPI host model: mode 0 frames, clock still between frames
`timescale 1ns/1ps
module sfpe_host
(
    output logic sck,
    output logic csN,
    output logic si,
    input wire logic so
);
    initial
    begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b1;
    end
    // Bytes go MSB first; rx keeps the last byte seen on so
    task automatic frame(input logic [7:0] b[], output logic [7:0] rx);
        rx = 8'h00;
        csN = 1'b0;
        #16;
        foreach (b[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                si = b[i][k];
                #16 sck = 1'b1;
                rx = {rx[6:0], so};
                #16 sck = 1'b0;
            end
        end
        #8 csN = 1'b1;
        // Released line flips so a stale level cannot pass as data
        si = ~si;
        #100;
    endtask
endmodule

// ---- dv/tb_top.sv ----
// Testbench for the program/erase sequencer
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic arst_n;
    logic wpN;
    logic [3:0] bp;
    logic hwEn;
    logic [7:0] rx;
    logic [7:0] mem [0:131071];
    wire sck, csN, si, so, soOe, hwAct, wel, busy, arrWe;
    wire [16:0] arrAddr;
    wire [7:0] arrWrData;
    wire [7:0] arrRdData;
    int err_total;
    int samples_checked;
    int cycles;

    sfpe_top #(.PROG_CYC(200), .CHIP_ERASE_CYC(200)) i_sfpe_top (
        .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(csN), .si(si),
        .so(so), .soOe(soOe), .wp_n(wpN), .blockProtectBitA(bp[0]),
        .blockProtectBitB(bp[1]), .blockProtectBitC(bp[2]),
        .blockProtectBitD(bp[3]), .hwProtectEnableBit(hwEn),
        .hwProtectActive(hwAct), .writeEnableLatch(wel), .busy(busy),
        .arrAddr(arrAddr), .arrWrData(arrWrData), .arrWe(arrWe),
        .arrRdData(arrRdData));
    sfpe_host i_sfpe_host (.sck(sck), .csN(csN), .si(si), .so(so));

    assign arrRdData = mem[arrAddr];
    always @(posedge clk)
    begin
        if (arrWe)
            mem[arrAddr] <= arrWrData;
    end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A run this short should end long before the ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] b[]);
        i_sfpe_host.frame(b, rx);
    endtask

    task automatic write_enable_cmd();
        send('{sfpe_pkg::OP_WRITE_ENABLE});
        check("wel", wel, 1'b1);
    endtask

    // Upper address bits are junk on purpose
    task automatic cmd(input logic [7:0] op, input logic [16:0] a);
        send('{op, {7'h55, a[16]}, a[15:8], a[7:0]});
    endtask

    task automatic status(input logic [7:0] exp);
        send('{sfpe_pkg::OP_STATUS_READ, 8'h00});
        check("status", rx, exp);
        check("soOe", soOe, 1'b0);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        check("idle", busy, 1'b0);
        repeat (4) @(posedge clk);
        #3;
    endtask

    task automatic noWel();
        send('{sfpe_pkg::OP_PAGE_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h00});
        check("busyNoWel", busy, 1'b0);
        repeat (250) @(posedge clk);
        #3;
        check("m100", mem[17'h00100], 8'hFF);
    endtask

    task automatic progWrap();
        write_enable_cmd();
        send('{sfpe_pkg::OP_PAGE_PROGRAM, 8'hFE, 8'h01, 8'hFE,
            8'hA5, 8'h3C, 8'h0F});
        check("busyProg", busy, 1'b1);
        status(8'h03);
        cmd(sfpe_pkg::OP_BLOCK_ERASE, 17'h00000);
        waitIdle();
        check("welEnd", wel, 1'b0);
        check("m1FE", mem[17'h001FE], 8'hA5);
        check("m1FF", mem[17'h001FF], 8'h3C);
        check("m100", mem[17'h00100], 8'h0F);
        check("m101", mem[17'h00101], 8'hFF);
    endtask

    task automatic progOver();
        logic [7:0] d[];
        d = new[261];
        d[0] = sfpe_pkg::OP_PAGE_PROGRAM;
        d[1] = 8'h00;
        d[2] = 8'h02;
        d[3] = 8'h00;
        for (int i = 0; i < 256; i++)
            d[4 + i] = 8'(i);
        d[260] = 8'h11;
        write_enable_cmd();
        send(d);
        waitIdle();
        check("m200", mem[17'h00200], 8'h11);
        check("m280", mem[17'h00280], 8'h80);
    endtask

    task automatic sectErase();
        mem[17'h01000] = 8'h00;
        write_enable_cmd();
        cmd(sfpe_pkg::OP_SECTOR_ERASE, 17'h00155);
        check("busySect", busy, 1'b1);
        waitIdle();
        check("m1FE", mem[17'h001FE], 8'hFF);
        check("m200", mem[17'h00200], 8'hFF);
        check("m1000", mem[17'h01000], 8'h00);
    endtask

    task automatic blkErase();
        mem[17'h07FFF] = 8'h00;
        mem[17'h08000] = 8'h00;
        mem[17'h0FFFF] = 8'h00;
        mem[17'h10000] = 8'h00;
        write_enable_cmd();
        cmd(sfpe_pkg::OP_BLOCK_ERASE, 17'h0ABCD);
        check("busyBlk", busy, 1'b1);
        waitIdle();
        check("welBlk", wel, 1'b0);
        check("m8000", mem[17'h08000], 8'hFF);
        check("mFFFF", mem[17'h0FFFF], 8'hFF);
        check("m7FFF", mem[17'h07FFF], 8'h00);
        check("m10000", mem[17'h10000], 8'h00);
    endtask

    // A full chip walk exceeds the run budget, so only a locked one runs
    task automatic protect();
        @(posedge clk);
        hwEn <= 1'b1;
        wpN <= 1'b0;
        bp <= 4'h2;
        repeat (5) @(posedge clk);
        #3;
        check("hwOn", hwAct, 1'b1);
        write_enable_cmd();
        status(8'h8A);
        cmd(sfpe_pkg::OP_SECTOR_ERASE, 17'h10000);
        check("busyLock", busy, 1'b0);
        check("m10000", mem[17'h10000], 8'h00);
        @(posedge clk);
        bp <= 4'h3;
        #3;
        cmd(sfpe_pkg::OP_CHIP_ERASE, 17'h00000);
        check("busyChip", busy, 1'b0);
        check("welKept", wel, 1'b1);
        @(posedge clk);
        wpN <= 1'b1;
        bp <= 4'h0;
        repeat (5) @(posedge clk);
        #3;
        check("hwOff", hwAct, 1'b0);
    endtask

    initial
    begin
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        arst_n = 1'b0;
        wpN = 1'b1;
        bp = 4'h0;
        hwEn = 1'b0;
        foreach (mem[i])
            mem[i] = 8'hFF;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #3;
        noWel();
        progWrap();
        progOver();
        sectErase();
        blkErase();
        protect();
        conclude();
    end
endmodule
